/* File: mcs_defs.svh */
// Constants for the microprogram control store block
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
`define MCS_ADDR_W      12
`define MCS_WORD_W      48
`define MCS_SENSE_W     60
`define MCS_MOD_WORDS   256
`define MCS_MODULES     8
`define MCS_SMALL_WORDS 2048
`define MCS_LARGE_WORDS 4096
`define MCS_HALF_W      6
`define MCS_RESET_ADDR  12'h000
`define MCS_SRC_OLD_CYL 4'h1
`define MCS_SRC_IE      4'h2
`define MCS_IE_STD_BIT  7
`define MCS_ALT_B5      5
`define MCS_ALT_B6      6
`define MCS_IE_B3       3
`endif

/* File: mcs_pkg.sv */
// Types for the microprogram control store block
package mcs_pkg;
  typedef struct packed {
    logic [15:0] misc;
    logic [3:0]  dest;
    logic [3:0]  b_src;
    logic [3:0]  a_src;
    logic [3:0]  alu_fn;
    logic [3:0]  branch_sel;
    logic [11:0] next_addr;
  } mcs_uword_t;

  typedef struct packed {
    logic [15:0] dest_strobe;
    logic [3:0]  alu_fn;
    logic [3:0]  b_src;
    logic [3:0]  a_src;
    logic [15:0] misc;
  } mcs_ctrl_t;
endpackage

/* File: mcs_rom.sv */
// Fixed read-only control store array with module/gate/driver decode
`timescale 1ns/10ps
`include "mcs_defs.svh"
module mcs_rom #(
  parameter bit LARGE_STORE = 1'b0
) (
  input  wire logic [11:0] i_addr,
  output logic      [47:0] o_word
);
  // Module, gate and driver fields of the address
  wire logic [5:0] gate_sel;
  wire logic [5:0] drv_sel;
  wire logic [2:0] module_no;
  wire logic       word_b;
  wire logic [11:0] a_addr;
  wire logic [11:0] b_addr;
  wire logic [59:0] a_sense;
  wire logic [59:0] b_sense;
  wire logic [59:0] sense;

  assign gate_sel  = {i_addr[11] & LARGE_STORE, i_addr[10:6]};
  assign drv_sel   = i_addr[5:0];
  assign module_no = i_addr[10:8];
  assign word_b    = gate_sel[0];
  assign a_addr    = {gate_sel[5:1], 1'b0, drv_sel};
  assign b_addr    = {gate_sel[5:1], 1'b1, drv_sel};

  // Fixed contents: each tape holds an A and a B word on 60 cores
  function automatic logic [59:0] tape_word(input logic [11:0] a);
    logic [59:0] w;
    w = {a[11:0], a ^ 12'ha5c, ~a, a[5:0], a[11:6], 12'h000};
    w[11:0] = a + 12'h001;
    return w;
  endfunction

  assign a_sense = tape_word(a_addr);
  assign b_sense = tape_word(b_addr);
  assign sense   = word_b ? b_sense : a_sense;
  // A sensed pulse is a one, no pulse a zero; top 12 cores unused
  assign o_word = sense[47:0];
  wire logic unused_ok;
  assign unused_ok = &{1'b0, module_no, sense[59:48]};
endmodule

/* File: mcs_top.sv */
// Microprogram sequencer front end: control store, latches, gates
// How it works
// - Gate selected drive's cylinder address onto A bus.
// - Standard tag bit 7 drives input element 7.
// - Alternate tag 5 to IE5; 6 to IE3,IE6.
// - One 48-bit word per read.
// - Latch each word, decode into controls.
// - Word field gives next address.
// - 12-bit address from upper and lower halves.
// - Small store holds 2048 words, eight modules.
// - Each module holds 256 words of 48 bits.
// - Twelve spare bit positions are ignored.
// - Store is read-only, no write path.
// - Optional feature gives a 4K store.
// - Each tape holds A and B words, one chosen.
// - Sensed pulse reads one, none reads zero.
// - Small store ignores top upper-address bit.
// - Bits 11-6 gate, 5-0 driver, 10-8 module.
`timescale 1ns/10ps
`include "mcs_defs.svh"
module mcs_top #(
  parameter bit LARGE_STORE = 1'b0
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_hold,
  input  wire logic [15:0]           i_cond,
  input  wire logic [7:0]            i_file_tag_reg,
  input  wire logic [7:0]            i_alt_file_tag_reg,
  input  wire logic [7:0]            i_cyl_addr,
  output logic      [11:0]           o_addr,
  output mcs_pkg::mcs_uword_t        o_uword,
  output mcs_pkg::mcs_ctrl_t         o_ctrl,
  output logic      [7:0]            o_input_element_gates,
  output logic      [7:0]            o_a_bus,
  output logic                       o_a_bus_valid
);
  logic [5:0]          upper_q;
  logic [5:0]          lower_q;
  logic [11:0]         addr_d;
  mcs_pkg::mcs_uword_t word_q;
  logic [47:0]         rom_word;
  logic [7:0]          cyl_s1_q;
  logic [7:0]          cyl_s2_q;
  logic [7:0]          cyl_s3_q;
  logic [7:0]          cyl_q;
  logic [7:0]          ie_q;
  logic [7:0]          a_bus_q;
  logic                a_valid_q;

  // Branch: selected condition ORs into the low address bit
  wire logic        br_enable;
  wire logic        br_cond;
  wire logic        br_take;
  wire logic [11:0] cur_addr;
  wire logic [11:0] next_raw;
  wire logic [11:0] next_addr;
  wire logic [5:0]  upper_d;
  wire logic [5:0]  lower_d;

  // Data path selects
  wire logic [7:0]  ie_d;
  wire logic        sel_old_cyl;
  wire logic        sel_ie;
  wire logic [7:0]  a_bus_d;
  wire logic        a_valid_d;
  wire logic [15:0] dest_hot;

  // Condition zero means no branch, so input 0 never steers
  assign br_enable = (word_q.branch_sel != 4'h0);
  assign br_cond   = i_cond[word_q.branch_sel];
  assign br_take   = br_enable & br_cond;
  assign cur_addr  = {upper_q, lower_q};
  assign next_raw  = {word_q.next_addr[11:1],
                      word_q.next_addr[0] | br_take};
  assign next_addr = LARGE_STORE ? next_raw
                                 : {1'b0, next_raw[10:0]};
  // Hold re-reads the word at the current address
  assign addr_d    = i_hold ? cur_addr : next_addr;
  assign upper_d   = addr_d[11:6];
  assign lower_d   = addr_d[5:0];

  // Store returns one word per address and has no write port
  mcs_rom #(
    .LARGE_STORE (LARGE_STORE)
  ) u_rom (
    .i_addr (addr_d),
    .o_word (rom_word)
  );

  // Address halves load addr_d every cycle, from zero after reset; hold reloads the current address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      upper_q <= 6'h00;
      lower_q <= 6'h00;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
    end
  end

  // Word latch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= '0;
    end else begin
      word_q <= rom_word;
    end
  end

  // Cylinder address from the drive crosses in through three stages
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cyl
      // Three-stage chain for the drive's level
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cyl_s1_q[gi] <= 1'b0;
          cyl_s2_q[gi] <= 1'b0;
          cyl_s3_q[gi] <= 1'b0;
        end else begin
          cyl_s1_q[gi] <= i_cyl_addr[gi];
          cyl_s2_q[gi] <= cyl_s1_q[gi];
          cyl_s3_q[gi] <= cyl_s2_q[gi];
        end
      end

      // Accept a new level only once the last two stages agree
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cyl_q[gi] <= 1'b0;
        end else if (cyl_s2_q[gi] == cyl_s3_q[gi]) begin
          cyl_q[gi] <= cyl_s3_q[gi];
        end
      end
    end
  endgenerate

  // Device type identification bits, one gate per position
  genvar ge;
  generate
    for (ge = 0; ge < 8; ge++) begin : g_ie
      if (ge == `MCS_IE_STD_BIT) begin : g_std
        assign ie_d[ge] = i_file_tag_reg[`MCS_IE_STD_BIT];
      end else if (ge == `MCS_ALT_B5) begin : g_alt5
        assign ie_d[ge] = i_alt_file_tag_reg[`MCS_ALT_B5];
      end else if (ge == `MCS_ALT_B6 || ge == `MCS_IE_B3) begin : g_alt6
        assign ie_d[ge] = i_alt_file_tag_reg[`MCS_ALT_B6];
      end else begin : g_none
        assign ie_d[ge] = 1'b0;
      end
    end
  endgenerate

  // A bus source picked by the latched word
  assign sel_old_cyl = (word_q.a_src == `MCS_SRC_OLD_CYL);
  assign sel_ie      = (word_q.a_src == `MCS_SRC_IE);
  assign a_bus_d     = sel_old_cyl ? cyl_q :
                       sel_ie      ? ie_d  : 8'h00;
  assign a_valid_d   = sel_old_cyl | sel_ie;

  // Input element gates
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ie_q <= 8'h00;
    end else begin
      ie_q <= ie_d;
    end
  end

  // A bus data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_bus_q <= 8'h00;
    end else begin
      a_bus_q <= a_bus_d;
    end
  end

  // A bus qualifier
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_valid_q <= 1'b0;
    end else begin
      a_valid_q <= a_valid_d;
    end
  end

  // One strobe per destination code
  genvar gd;
  generate
    for (gd = 0; gd < 16; gd++) begin : g_dest
      assign dest_hot[gd] = (word_q.dest == 4'(gd));
    end
  endgenerate

  // Latched word fields, high to low: misc, dest, b_src, a_src,
  // alu_fn, branch_sel, next_addr; controls below decode them
  assign o_ctrl.dest_strobe = dest_hot;
  assign o_ctrl.alu_fn      = word_q.alu_fn;
  assign o_ctrl.a_src       = word_q.a_src;
  assign o_ctrl.b_src       = word_q.b_src;
  assign o_ctrl.misc        = word_q.misc;

  // Outputs straight from flip-flops
  assign o_addr                = cur_addr;
  assign o_uword               = word_q;
  assign o_input_element_gates = ie_q;
  assign o_a_bus               = a_bus_q;
  assign o_a_bus_valid         = a_valid_q;
endmodule

/* File: mcs_top_assertions.sv */
// Port checks for the control store front end
`timescale 1ns/10ps
module mcs_chk #(
  parameter bit LARGE_STORE = 1'b0
) (
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                i_hold,
  input wire logic [15:0]         i_cond,
  input wire logic [7:0]          i_file_tag_reg,
  input wire logic [7:0]          i_alt_file_tag_reg,
  input wire logic [11:0]         o_addr,
  input wire mcs_pkg::mcs_uword_t o_uword,
  input wire mcs_pkg::mcs_ctrl_t  o_ctrl,
  input wire logic [7:0]          o_input_element_gates,
  input wire logic [7:0]          o_a_bus,
  input wire logic                o_a_bus_valid
);
  localparam logic [11:0] AMASK = LARGE_STORE ? 12'hfff : 12'h7ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_start_at_zero: assert property (
    !$past(i_rst_n) |-> o_addr == 12'h000)
    else $error("first address not zero");
  chk_next_from_word: assert property (
    $past(i_rst_n) && !$past(i_hold) && $past(o_uword.branch_sel) == 4'h0
    |-> o_addr == ($past(o_uword.next_addr) & AMASK))
    else $error("next address not from word");
  chk_branch_taken: assert property (
    $past(i_rst_n) && !$past(i_hold) && $past(o_uword.branch_sel) != 4'h0
    && $past(i_cond[o_uword.branch_sel]) |-> o_addr[0])
    else $error("branch not applied");
  chk_hold_freezes: assert property (
    $past(i_rst_n) && $past(i_hold) |-> $stable(o_addr) && $stable(o_uword))
    else $error("address moved in hold");
  chk_small_top_bit: assert property (
    !LARGE_STORE |-> !o_addr[11])
    else $error("top address bit set");
  chk_dest_decode: assert property (
    o_ctrl.dest_strobe == (16'h0001 << o_uword.dest))
    else $error("destination decode wrong");
  chk_ie_map: assert property (
    $past(i_rst_n) |-> o_input_element_gates ==
    {$past(i_file_tag_reg[7]), $past(i_alt_file_tag_reg[6:5]), 1'b0,
     $past(i_alt_file_tag_reg[6]), 3'h0})
    else $error("input element gates wrong");
  chk_bus_valid: assert property (
    $past(i_rst_n) |-> o_a_bus_valid ==
    ($past(o_uword.a_src) inside {4'h1, 4'h2}))
    else $error("bus valid wrong");
  chk_bus_idle: assert property (
    !o_a_bus_valid |-> o_a_bus == 8'h00)
    else $error("bus not idle");
endmodule
bind mcs_top mcs_chk #(.LARGE_STORE(LARGE_STORE)) u_chk (.i_clk, .i_rst_n,
  .i_hold, .i_cond, .i_file_tag_reg, .i_alt_file_tag_reg, .o_addr, .o_uword,
  .o_ctrl, .o_input_element_gates, .o_a_bus, .o_a_bus_valid);

/* File: mcs_far_model.sv */
// Far-side registers: device tags and the selected drive's cylinder
`timescale 1ns/10ps
module mcs_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_load,
  input  wire logic [7:0] i_tag,
  input  wire logic [7:0] i_alt,
  input  wire logic [7:0] i_cyl,
  output logic      [7:0] o_tag,
  output logic      [7:0] o_alt,
  output logic      [7:0] o_cyl
);
  // Held across control unit resets, changed only by a load
  always_ff @(posedge i_clk) begin
    if (i_load) begin
      o_tag <= i_tag;
      o_alt <= i_alt;
      o_cyl <= i_cyl;
    end
  end
endmodule

/* File: tb_top.sv */
// Random and corner stimulus for the control store front end
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, hold, ld;
  logic [15:0] cond;
  logic [7:0] tag, alt, cyl, ft, aft, ca, ie, ab;
  logic [11:0] addr;
  logic ab_v;
  mcs_pkg::mcs_uword_t uw;
  mcs_pkg::mcs_ctrl_t ctrl;
  logic [11:0] exp_nxt;
  logic [3:0] src_prev;
  logic settled;
  int mismatches, check_count;
  mcs_far_model far (.i_clk(clk), .i_load(ld), .i_tag(tag), .i_alt(alt),
    .i_cyl(cyl), .o_tag(ft), .o_alt(aft), .o_cyl(ca));
  mcs_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_hold(hold), .i_cond(cond),
    .i_file_tag_reg(ft), .i_alt_file_tag_reg(aft), .i_cyl_addr(ca),
    .o_addr(addr), .o_uword(uw), .o_ctrl(ctrl), .o_input_element_gates(ie),
    .o_a_bus(ab), .o_a_bus_valid(ab_v));
  function automatic logic [7:0] ie_exp(logic [7:0] t, logic [7:0] a);
    return {t[7], a[6], a[5], 1'b0, a[6], 3'h0};
  endfunction
  task automatic check(string n, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #60000;
    mismatches++;
    summarize();
  end
  initial begin
    {rst_n, hold, cond, tag, alt, cyl} = '0;
    ld = 1;
    void'($urandom(32'h52e1));
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    exp_nxt = 12'h000;
    src_prev = 4'h0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #2;
      settled = (i % 50 > 8) && !(i >= 220 && i < 229);
      if (i == 0 || i == 220) check("start", addr, 12'h000);
      else check("follow", addr, exp_nxt);
      check("next", {1'b0, uw.next_addr[10:0]},
            {1'b0, addr[10:0] + 11'h1});
      check("top", {11'h0, addr[11]}, 12'h000);
      check("dest", {11'h0, ctrl.dest_strobe[uw.dest]}, 12'h001);
      check("onehot", 12'($countones(ctrl.dest_strobe)), 12'h001);
      check("valid", {11'h0, ab_v},
            {11'h0, src_prev inside {4'h1, 4'h2}});
      if (settled) begin
        check("ie", ie, ie_exp(tag, alt));
        check("abus", ab, src_prev == 4'h1 ? cyl :
              src_prev == 4'h2 ? ie_exp(tag, alt) : 8'h00);
      end
      src_prev = uw.a_src;
      ld = (i % 50 == 0);
      if (ld) {tag, alt, cyl} = i == 0 ? 24'hffffff : 24'($urandom);
      hold = ($urandom % 6 == 0);
      cond = 16'($urandom);
      exp_nxt = hold ? addr : {1'b0, uw.next_addr[10:1], uw.next_addr[0]
                | (uw.branch_sel != 4'h0 && cond[uw.branch_sel])};
      if (i == 219) begin
        rst_n = 0;
        @(posedge clk);
        #2 rst_n = 1;
        src_prev = 4'h0;
      end
    end
    summarize();
  end
endmodule
